// file: pll_ctl_pkg.sv
package pll_ctl_pkg;
	localparam int NUM_POST = 10;
	localparam int NUM_EXT = 4;
	localparam int CNT_W = 11;
	localparam int TAP_W = 3;
	localparam int DLY_W = 4;
	localparam int NUM_PINS = 7;
	// Positions of the sampled pins in the synchroniser vector
	localparam int PIN_PRI = 0;
	localparam int PIN_SEC = 1;
	localparam int PIN_MAN = 2;
	localparam int PIN_LOCK = 3;
	localparam int PIN_SCK = 4;
	localparam int PIN_SDI = 5;
	localparam int PIN_CLR = 6;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TAPS = 8'h08;
	localparam logic [7:0] ADDR_ACTIVE_NM = 8'h0C;
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CTRL_SWITCH_BIT = 2;
	localparam int ST_LOST_BIT = 0;
	localparam int ST_RELOCK_BIT = 1;
	localparam int ST_CFGERR_BIT = 2;
	localparam int ST_SEL_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_LOCK_BIT = 5;
	// Count limits
	localparam logic [CNT_W-1:0] CNT_MIN = 11'h001;
	localparam logic [CNT_W-1:0] MAX_50 = 11'h400;
	localparam logic [CNT_W-1:0] MAX_OTHER = 11'h200;
	localparam logic [CNT_W-1:0] MAX_NM = 11'h200;
	localparam logic [CNT_W-1:0] MAX_FAST = 11'h020;
	localparam int CHAIN_BITS = 2 * CNT_W + NUM_POST * (CNT_W + 1)
		+ NUM_EXT * DLY_W;
	localparam logic [7:0] CHAIN_LAST = 8'(CHAIN_BITS - 1);
	// Timing
	localparam int CLK_MHZ = 100;
	localparam logic [7:0] LOSS_CYCLES = 8'h40;
	localparam int RELOCK_TIME_US = 100;
	localparam int RELOCK_CYCLES_DEF = RELOCK_TIME_US * CLK_MHZ;
	localparam int CFG_TIME_US = 20;
	localparam int SHIFT_CLK_MHZ = 25;
	localparam int CFG_MAX_SHIFTS = CFG_TIME_US * SHIFT_CLK_MHZ;

	typedef struct packed {
		logic [NUM_EXT-1:0][DLY_W-1:0] delay;
		logic [NUM_POST-1:0] duty50;
		logic [NUM_POST-1:0][CNT_W-1:0] post;
		logic [CNT_W-1:0] m;
		logic [CNT_W-1:0] n;
	} pll_cfg_t;

	localparam pll_cfg_t CFG_RESET = '{delay: '0, duty50: '1,
		post: {NUM_POST{11'h001}}, m: 11'h001, n: 11'h001};

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic {SW_IDLE, SW_WAIT_LOW} sw_state_t;
endpackage

// file: pll_divider.sv
`timescale 1ns/1ns
module pll_divider
	import pll_ctl_pkg::*;
(
	input logic clk,
	input logic srst,
	input logic run,
	input logic [CNT_W-1:0] count,
	input logic duty50,
	output logic div_out,
	output logic tick
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic out;
		logic tick;
	} div_state_t;

	div_state_t s;
	div_state_t n;
	logic [CNT_W-1:0] hi;

	always_comb begin
		n = s;
		// High for the larger half; odd counts leave low one cycle shorter
		hi = duty50 ? count - {1'b0, count[CNT_W-1:1]} : CNT_MIN;
		if (!run || s.cnt >= count - CNT_MIN) begin
			n.cnt = '0;
		end else begin
			n.cnt = s.cnt + 11'h001;
		end
		n.out = run && (n.cnt < hi);
		n.tick = run && (n.cnt == '0);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign div_out = s.out;
	assign tick = s.tick;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	high_time_a: assert property (
		run && $past(run) && $stable(count) && $stable(duty50)
		&& $past(s.cnt) != s.cnt && s.cnt >= hi |-> !s.out)
		else $error("divider output high past its half count");
	period_wrap_a: assert property (
		run && $stable(count) && s.cnt == count - CNT_MIN
		##1 run && $stable(count) |-> s.cnt == '0 && s.tick)
		else $error("divider did not wrap at its programmed count");
endmodule

// file: pll_counter_switchover_reconfig.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Output counters run to 1024 at 50 percent duty, else only 512.
// - Fast variant limits loop divisor and output counters to 1..32.
// - Finest phase step is one eighth oscillator period via eight taps.
// - Degree steps of 45 or finer exist for every output.
// - Fast instances 7,8 get two outputs; instances 1,2 get three.
// - Reference divided by pre-divider; outputs divide oscillator.
// - One pre-divider and one loop divisor, each 1..512.
// - Two regional, four global, four external counters, each 1..512, or 1..1024 at 50 percent duty.
// - Dead primary reference moves the loop to the secondary.
// - Automatic mode state machine drives the reference select.
// - Reference switch happens without glitches; oscillator keeps running.
// - Lock returns within 100 us after a switch.
// - Runtime reconfiguration touches counters and delays only.
// - After the last bit, a chain with all counts in range loads into the active set at once; any other chain sets the config error flag.
// - A clear input empties the whole shift chain.
// - Full reconfiguration under 20 us at a 25 MHz shift clock.
module pll_counter_switchover_reconfig
	import pll_ctl_pkg::*;
#(
	parameter int RELOCK_CYCLES = RELOCK_CYCLES_DEF,
	parameter int INSTANCE = 5,
	parameter bit FAST_VARIANT = 1'b0
)(
	input logic clk,
	input logic srst,
	input reg_req_t reg_req,
	output logic [31:0] rd_data,
	input logic primary_reference_input,
	input logic secondary_reference_input,
	input logic manual_switch_request,
	input logic loop_locked,
	input logic shift_clk,
	input logic shift_data,
	input logic shift_clear,
	output logic ref_select,
	output logic switch_busy,
	output logic ref_div_pulse,
	output logic fb_div_pulse,
	output logic [NUM_POST-1:0] post_clk,
	output logic [NUM_POST-1:0][TAP_W-1:0] phase_tap,
	output logic [NUM_EXT-1:0][DLY_W-1:0] delay_sel
);
	// Output ports present in this instance
	localparam logic [NUM_POST-1:0] PORT_MASK =
		!FAST_VARIANT ? 10'h3FF :
		(INSTANCE == 7 || INSTANCE == 8) ? 10'h003 :
		(INSTANCE == 1 || INSTANCE == 2) ? 10'h007 : 10'h3FF;

	typedef struct packed {
		logic [NUM_PINS-1:0] st0;
		logic [NUM_PINS-1:0] st1;
		logic [NUM_PINS-1:0] st2;
		logic [NUM_PINS-1:0] lvl;
		logic auto_en;
		logic run;
		logic [NUM_POST-1:0][TAP_W-1:0] taps;
		logic lost;
		logic relock_to;
		logic cfg_err;
		sw_state_t sw;
		logic sel;
		logic ref_lvl;
		logic ref_pulse;
		logic [7:0] miss_cnt;
		logic relock_wait;
		logic [15:0] relock_cnt;
		logic [CHAIN_BITS-1:0] chain;
		logic [7:0] bit_cnt;
		logic [CNT_W-1:0] n_cnt;
		pll_cfg_t active;
		logic [31:0] rd_data;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t n;
	logic [NUM_PINS-1:0] pins;
	logic [NUM_PINS-1:0] rise;
	logic [NUM_PINS-1:0] chg;
	logic dead;
	logic sw_req;
	logic tgt_lvl;
	logic ref_cur;
	logic lost_set;
	logic relock_set;
	logic cfg_set;
	logic [2:0] clr;
	logic wr_ctrl;

	function automatic logic cfg_ok(input pll_cfg_t c);
		logic ok;
		logic [CNT_W-1:0] lim;
		ok = (c.n >= CNT_MIN) && (c.n <= MAX_NM);
		lim = FAST_VARIANT ? MAX_FAST : MAX_NM;
		ok = ok && (c.m >= CNT_MIN) && (c.m <= lim);
		for (int i = 0; i < NUM_POST; i++) begin
			lim = c.duty50[i] ? MAX_50 : MAX_OTHER;
			if (FAST_VARIANT) begin
				lim = MAX_FAST;
			end
			ok = ok && (c.post[i] >= CNT_MIN) && (c.post[i] <= lim);
		end
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = s;
		pins = {shift_clear, shift_data, shift_clk, loop_locked,
			manual_switch_request, secondary_reference_input,
			primary_reference_input};
		n.st0 = pins;
		n.st1 = s.st0;
		n.st2 = s.st1;
		// A level counts once the second and third stages agree
		n.lvl = (s.st2 & ~(s.st1 ^ s.st2)) | (s.lvl & (s.st1 ^ s.st2));
		rise = n.lvl & ~s.lvl;
		chg = n.lvl ^ s.lvl;
		n.rd_data = '0;
		n.ref_pulse = 1'b0;
		lost_set = 1'b0;
		relock_set = 1'b0;
		cfg_set = 1'b0;
		wr_ctrl = reg_req.wr && reg_req.addr == ADDR_CTRL;
		clr = (reg_req.wr && reg_req.addr == ADDR_STATUS) ?
			reg_req.wdata[2:0] : 3'h0;

		// Clock sensing on the primary reference
		if (chg[PIN_PRI]) begin
			n.miss_cnt = '0;
		end else if (s.miss_cnt != LOSS_CYCLES) begin
			n.miss_cnt = s.miss_cnt + 8'h01;
		end
		dead = (s.miss_cnt == LOSS_CYCLES);
		lost_set = (n.miss_cnt == LOSS_CYCLES) && !dead;

		// Lock watch after a switch
		if (s.relock_wait) begin
			if (s.relock_cnt == 16'(RELOCK_CYCLES - 1)) begin
				n.relock_wait = 1'b0;
				relock_set = !s.lvl[PIN_LOCK];
			end else begin
				n.relock_cnt = s.relock_cnt + 16'h0001;
			end
		end

		// Switchover; swap only while the incoming reference is low
		sw_req = rise[PIN_MAN]
			|| (wr_ctrl && reg_req.wdata[CTRL_SWITCH_BIT])
			|| (s.auto_en && dead && !s.sel);
		tgt_lvl = s.sel ? n.lvl[PIN_PRI] : n.lvl[PIN_SEC];
		case (s.sw)
			SW_IDLE: begin
				if (sw_req) begin
					n.sw = SW_WAIT_LOW;
				end
			end
			SW_WAIT_LOW: begin
				if (!tgt_lvl) begin
					n.sel = ~s.sel;
					n.sw = SW_IDLE;
					n.relock_wait = 1'b1;
					n.relock_cnt = '0;
				end
			end
			default: begin
				n.sw = SW_IDLE;
			end
		endcase

		// Pre-divider on rising edges of the selected reference
		ref_cur = s.sel ? n.lvl[PIN_SEC] : n.lvl[PIN_PRI];
		n.ref_lvl = ref_cur;
		if (!s.run) begin
			n.n_cnt = '0;
		end else if (ref_cur && !s.ref_lvl) begin
			if (s.n_cnt >= s.active.n - CNT_MIN) begin
				n.n_cnt = '0;
				n.ref_pulse = 1'b1;
			end else begin
				n.n_cnt = s.n_cnt + 11'h001;
			end
		end

		// Serial chain; clear acts without any shift clock edge
		if (n.lvl[PIN_CLR]) begin
			n.chain = '0;
			n.bit_cnt = '0;
		end else if (rise[PIN_SCK]) begin
			n.chain = {s.chain[CHAIN_BITS-2:0], n.lvl[PIN_SDI]};
			if (s.bit_cnt == CHAIN_LAST) begin
				n.bit_cnt = '0;
				if (cfg_ok(pll_cfg_t'(n.chain))) begin
					n.active = pll_cfg_t'(n.chain);
				end else begin
					cfg_set = 1'b1;
				end
			end else begin
				n.bit_cnt = s.bit_cnt + 8'h01;
			end
		end

		// Register writes
		if (wr_ctrl) begin
			n.auto_en = reg_req.wdata[CTRL_AUTO_BIT];
			n.run = reg_req.wdata[CTRL_RUN_BIT];
		end
		if (reg_req.wr && reg_req.addr == ADDR_TAPS && !s.run) begin
			n.taps = reg_req.wdata[NUM_POST*TAP_W-1:0];
		end
		n.lost = (s.lost & ~clr[ST_LOST_BIT]) | lost_set;
		n.relock_to = (s.relock_to & ~clr[ST_RELOCK_BIT]) | relock_set;
		n.cfg_err = (s.cfg_err & ~clr[ST_CFGERR_BIT]) | cfg_set;

		// Register reads
		if (reg_req.rd) begin
			case (reg_req.addr)
				ADDR_CTRL: n.rd_data = {30'h0, s.run, s.auto_en};
				ADDR_STATUS: n.rd_data = {26'h0, s.lvl[PIN_LOCK],
					s.sw == SW_WAIT_LOW, s.sel, s.cfg_err,
					s.relock_to, s.lost};
				ADDR_TAPS: n.rd_data = {2'h0, s.taps};
				ADDR_ACTIVE_NM: n.rd_data = {5'h0, s.active.m,
					5'h0, s.active.n};
				default: n.rd_data = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
			s.active <= CFG_RESET;
			s.sw <= SW_IDLE;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The block clock stands in for the oscillator
	pll_divider loop_div (
		.clk(clk),
		.srst(srst),
		.run(s.run),
		.count(s.active.m),
		.duty50(1'b1),
		.div_out(),
		.tick(fb_div_pulse)
	);

	for (genvar i = 0; i < NUM_POST; i++) begin : g_post
		pll_divider post_div (
			.clk(clk),
			.srst(srst),
			.run(s.run && PORT_MASK[i]),
			.count(s.active.post[i]),
			.duty50(s.active.duty50[i]),
			.div_out(post_clk[i]),
			.tick()
		);
	end

	assign rd_data = s.rd_data;
	assign ref_select = s.sel;
	assign switch_busy = (s.sw == SW_WAIT_LOW);
	assign ref_div_pulse = s.ref_pulse;
	// Eight taps per oscillator period, one per output counter
	assign phase_tap = s.taps;
	assign delay_sel = s.active.delay;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sel_glitch_free_a: assert property (
		$changed(ref_select) |->
		!(ref_select ? s.lvl[PIN_SEC] : s.lvl[PIN_PRI]))
		else $error("reference select moved while new input high");
	auto_switch_a: assert property (
		s.sw == SW_IDLE && s.auto_en && dead && !s.sel
		|=> s.sw == SW_WAIT_LOW)
		else $error("automatic switch not started on dead primary");
	sense_loss_a: assert property (
		$rose(s.lost) |-> s.miss_cnt == LOSS_CYCLES
		&& $past(s.miss_cnt) == LOSS_CYCLES - 8'h01)
		else $error("primary loss flagged at wrong count");
	load_chain_a: assert property (
		!n.lvl[PIN_CLR] && rise[PIN_SCK] && s.bit_cnt == CHAIN_LAST
		&& cfg_ok(pll_cfg_t'(n.chain)) |=> s.active == $past(n.chain))
		else $error("chain not loaded after last bit");
	clear_chain_a: assert property (
		n.lvl[PIN_CLR] |=> s.chain == '0 && s.bit_cnt == '0)
		else $error("chain not cleared");
	post_range_a: assert property (
		cfg_ok(s.active))
		else $error("active counts out of range");
	nm_range_a: assert property (
		s.active.n >= CNT_MIN && s.active.n <= MAX_NM
		&& s.active.m >= CNT_MIN)
		else $error("pre-divider or loop divisor out of range");
	taps_fixed_a: assert property (
		s.run && $past(s.run) |-> $stable(s.taps))
		else $error("phase taps changed while running");
	relock_bound_a: assert property (
		s.relock_wait |-> s.relock_cnt < 16'(RELOCK_CYCLES))
		else $error("relock wait overran its limit");
	ndiv_pulse_a: assert property (
		ref_div_pulse |-> s.n_cnt == '0
		&& $past(s.n_cnt) >= $past(s.active.n) - CNT_MIN)
		else $error("pre-divider pulse at wrong count");
endmodule

// file: cfg_shifter.sv
`timescale 1ns/1ns
module cfg_shifter
	import pll_ctl_pkg::*;
(
	input wire logic clk,
	output logic shift_clk,
	output logic shift_data
);
	// Shift clock stands low between frames; data goes to the inverse
	initial begin
		shift_clk = 1'b0;
		shift_data = 1'b0;
	end

	task automatic send(input logic [CHAIN_BITS-1:0] w, input int nbits);
		for (int i = CHAIN_BITS - 1; i >= CHAIN_BITS - nbits; i--) begin
			shift_data <= w[i];
			repeat (8) @(posedge clk);
			shift_clk <= 1'b1;
			repeat (8) @(posedge clk);
			shift_clk <= 1'b0;
		end
		shift_data <= ~shift_data;
	endtask
endmodule

// file: pll_counter_switchover_reconfig_test.sv
`timescale 1ns/1ns
module pll_counter_switchover_reconfig_test
	import pll_ctl_pkg::*;
;
	logic clk, srst, pri, sec, man, lock, clr, pri_run, sck, sdi;
	reg_req_t req;
	logic [31:0] rd_data;
	logic ref_select, switch_busy, ref_div_pulse, fb_div_pulse;
	logic [NUM_POST-1:0] post_clk;
	logic [NUM_POST-1:0][TAP_W-1:0] phase_tap;
	logic [NUM_EXT-1:0][DLY_W-1:0] delay_sel;
	pll_cfg_t c, act;
	int failures, comparisons, cyc, n, p, h, b0;
	int busy_n = 0;

	pll_counter_switchover_reconfig #(.RELOCK_CYCLES(200)) i_dut (
		.clk(clk), .srst(srst), .reg_req(req), .rd_data(rd_data),
		.primary_reference_input(pri), .secondary_reference_input(sec),
		.manual_switch_request(man), .loop_locked(lock),
		.shift_clk(sck), .shift_data(sdi), .shift_clear(clr),
		.ref_select(ref_select), .switch_busy(switch_busy),
		.ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
		.post_clk(post_clk), .phase_tap(phase_tap), .delay_sel(delay_sel));

	cfg_shifter i_far (.clk(clk), .shift_clk(sck), .shift_data(sdi));

	// Cycles with a swap pending, seen at falling edges
	always @(negedge clk)
		if (switch_busy) busy_n <= busy_n + 1;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Equal-frequency references and the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pri_run && cyc % 4 == 0) pri <= ~pri;
		if (cyc % 4 == 2) sec <= ~sec;
		if (cyc == 60000) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////
	function automatic logic cfg_ok(pll_cfg_t x);
		logic ok;
		ok = x.n inside {[11'h001:11'h200]} && x.m inside {[11'h001:11'h200]};
		for (int i = 0; i < NUM_POST; i++)
			if (x.post[i] < 11'h001 ||
				x.post[i] > (x.duty50[i] ? 11'h400 : 11'h200)) ok = 1'b0;
		return ok;
	endfunction

	function automatic pll_cfg_t rnd_cfg();
		pll_cfg_t x;
		x.delay = 16'($urandom);
		x.duty50 = 10'($urandom);
		x.n = 11'($urandom_range(512, 1));
		x.m = 11'($urandom_range(512, 1));
		for (int i = 0; i < NUM_POST; i++)
			x.post[i] = 11'($urandom_range(512, 1));
		return x;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		comparisons++;
		if (got !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rd_data, e);
		@(posedge clk);
	endtask

	task automatic load(input pll_cfg_t x);
		i_far.send(x, CHAIN_BITS);
		repeat (8) @(posedge clk);
		if (cfg_ok(x)) act = x;
		rchk(ADDR_ACTIVE_NM, {5'h00, act.m, 5'h00, act.n});
		rchk(ADDR_STATUS, {29'h0, !cfg_ok(x), 2'h0});
		chk(32'(delay_sel), 32'(act.delay));
		wr(ADDR_STATUS, 32'h4);
	endtask

	// Counts falling edges until the watched output reaches v
	task automatic gap(input int sel, input logic v, output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while ((sel == 2 ? ref_div_pulse : sel == 1 ? ref_select :
			fb_div_pulse) !== v && k < 2000);
		@(posedge clk);
	endtask

	// One period of an output counter: its length and its high cycles
	task automatic meas(input int i, output int per, output int hi);
		logic prev;
		int k;
		k = 0;
		per = 0;
		hi = 0;
		do begin
			prev = post_clk[i];
			@(negedge clk);
			k++;
		end while (!(post_clk[i] && !prev) && k < 2000);
		do begin
			hi += post_clk[i];
			per++;
			prev = post_clk[i];
			@(negedge clk);
		end while (!(post_clk[i] && !prev) && per < 2000);
		@(posedge clk);
	endtask

	task automatic print_verdict();
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		req = '0;
		{pri, sec, man, lock, clr} = 5'h00;
		pri_run = 1'b1;
		cyc = 0;
		failures = 0;
		comparisons = 0;
		act = CFG_RESET;
		n = $urandom(10445);
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rchk(ADDR_ACTIVE_NM, 32'h0001_0001);
		rchk(ADDR_STATUS, 32'h0);
		wr(8'h10, 32'hFFFF_FFFF);
		rchk(8'h10, 32'h0);
		rchk(ADDR_CTRL, 32'h0);
		c = rnd_cfg();
		c.n = 11'h200;
		c.post[0] = 11'h400;
		c.duty50[0] = 1'b1;
		load(c);
		c = rnd_cfg();
		c.m = 11'h000;
		load(c);
		c = rnd_cfg();
		c.n = 11'h201;
		load(c);
		c = rnd_cfg();
		c.post[3] = 11'h201;
		c.duty50[3] = 1'b0;
		load(c);
		c = rnd_cfg();
		c.post[9] = 11'h401;
		c.duty50[9] = 1'b1;
		load(c);
		c = rnd_cfg();
		c.post[6] = 11'h000;
		load(c);
		for (int k = 0; k < 3; k++)
			load(rnd_cfg());
		i_far.send(rnd_cfg(), 50);
		clr <= 1'b1;
		repeat (8) @(posedge clk);
		clr <= 1'b0;
		c = rnd_cfg();
		c.m = 11'h00D;
		c.n = 11'h003;
		c.post[2] = 11'h007;
		c.duty50[2] = 1'b1;
		c.post[7] = 11'h005;
		c.duty50[7] = 1'b0;
		load(c);
		wr(ADDR_TAPS, 32'h1234_5678);
		wr(ADDR_CTRL, 32'h2);
		wr(ADDR_TAPS, 32'h0);
		rchk(ADDR_TAPS, 32'h1234_5678);
		chk(32'(phase_tap), 32'h1234_5678);
		gap(0, 1'b1, n);
		gap(0, 1'b1, n);
		chk(32'(n), 32'h0000_000D);
		// Three primary rises of eight cycles each per pre-divider pulse
		gap(2, 1'b1, n);
		gap(2, 1'b1, n);
		chk(32'(n), 32'h0000_0018);
		meas(2, p, h);
		chk(32'(p), 32'h0000_0007);
		chk(32'((2 * h - p) inside {[-1:1]}), 32'h1);
		meas(7, p, h);
		chk(32'(p), 32'h0000_0005);
		chk(32'(h), 32'h0000_0001);
		lock <= 1'b1;
		b0 = busy_n;
		wr(ADDR_CTRL, 32'h6);
		gap(1, 1'b1, n);
		chk(32'((busy_n - b0) inside {[1:8]}), 32'h1);
		repeat (250) @(posedge clk);
		rchk(ADDR_STATUS, 32'h28);
		lock <= 1'b0;
		b0 = busy_n;
		man <= 1'b1;
		gap(1, 1'b0, n);
		chk(32'((busy_n - b0) inside {[1:8]}), 32'h1);
		repeat (250) @(posedge clk);
		rchk(ADDR_STATUS, 32'h2);
		wr(ADDR_STATUS, 32'h2);
		man <= 1'b0;
		lock <= 1'b1;
		wr(ADDR_CTRL, 32'h3);
		pri_run <= 1'b0;
		gap(1, 1'b1, n);
		rchk(ADDR_STATUS, 32'h29);
		wr(ADDR_STATUS, 32'h1);
		rchk(ADDR_STATUS, 32'h28);
		print_verdict();
	end
endmodule
